/* File: core/osl_pkg.sv */
// constants, encodings and types for the oscillator lock and fail recovery block
package osl_pkg;
	// bus geometry
	localparam int          ADDR_W   = 8;
	localparam int          DATA_W   = 32;
	// register byte offsets
	localparam logic [7:0]  OFF_OSC  = 8'h00;
	localparam logic [7:0]  OFF_STS  = 8'h04;
	localparam logic [7:0]  OFF_MSK  = 8'h08;
	localparam logic [7:0]  OFF_STAT = 8'h0C;
	// oscillator control register fields
	localparam int          B_IPO    = 7;
	localparam int          B_XTAL   = 6;
	localparam int          B_WDTOSC = 5;
	localparam int          B_PFEN   = 4;
	localparam int          B_WFEN   = 3;
	localparam int          SEL_LO   = 0;
	localparam int          SEL_W    = 3;
	localparam logic [7:0]  OSC_RST  = 8'hA0;
	// clock source codes
	localparam logic [2:0]  SRC_IPO  = 3'h0;
	localparam logic [2:0]  SRC_WDT  = 3'h3;
	// unlock keys
	localparam logic [7:0]  KEY_1    = 8'hE7;
	localparam logic [7:0]  KEY_2    = 8'h18;
	// status and mask bits
	localparam int          ST_W     = 2;
	localparam int          ST_FAIL  = 0;
	localparam int          ST_IGN   = 1;
	// state readback fields
	localparam int          RB_FSM   = 0;
	localparam int          RB_REC   = 3;
	localparam int          RB_SRC   = 4;
	// fail detection timing
	localparam int          CLK_NS   = 5;
	localparam int          FAIL_NS  = 1000000;
	localparam int          FAIL_CYC = FAIL_NS / CLK_NS;
	localparam int          CNT_W    = 24;
	// unlock tracker states
	typedef enum logic [2:0] {
		LK_LOCKED = 3'b001,
		LK_KEY1   = 3'b010,
		LK_OPEN   = 3'b100
	} osl_lock_t;
endpackage

/* File: core/osl_top.sv */
// oscillator select lock, primary fail detection and watchdog recovery, apb slave
`timescale 1ns/1ps
module osl_top
	import osl_pkg::*;
#(
	parameter int FAIL_CYCLES = FAIL_CYC
) (
	// clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	// primary oscillator activity, asynchronous pin
	input  wire logic              prim_osc_in,
	// oscillator controls
	output logic                   ipo_en,
	output logic                   xtal_en,
	output logic                   wdt_osc_en,
	output logic      [SEL_W-1:0]  clk_src,
	output logic                   recovery,
	// events
	output logic                   nmi,
	output logic                   irq
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		osl_lock_t          fsm;
		logic [7:0]         osc;
		logic               rec;
		logic [ST_W-1:0]    sts;
		logic [ST_W-1:0]    msk;
		logic [CNT_W-1:0]   cnt;
		logic [2:0]         sy;
		logic [DATA_W-1:0]  rdata;
		logic               rdy;
		logic               err;
		logic               irq;
		logic               nmi;
		logic [SEL_W-1:0]   src;
	} osl_state_t;

	osl_state_t s_q;
	osl_state_t s_d;

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic setup;
	logic access;
	logic wr;
	logic osc_wr;
	logic mapped;
	logic edge_seen;
	logic fail_ev;
	logic det_en;
	logic ign_ev;

	// access phase completes on the same edge pready is sampled high
	assign setup   = psel & ~penable;
	assign access  = psel & penable & s_q.rdy;
	assign wr      = access & pwrite;
	assign osc_wr  = wr & (paddr == OFF_OSC);
	assign mapped  = (paddr == OFF_OSC) | (paddr == OFF_STS) |
	                 (paddr == OFF_MSK) | (paddr == OFF_STAT);
	// a control write that breaks or skips the key pair is flagged
	assign ign_ev  = osc_wr &
	                 (((s_q.fsm == LK_LOCKED) & (pwdata[7:0] != KEY_1)) |
	                  ((s_q.fsm == LK_KEY1) & (pwdata[7:0] != KEY_1) &
	                   (pwdata[7:0] != KEY_2)));

	// detector looks only at the second and third sync stages
	assign edge_seen = s_q.sy[1] ^ s_q.sy[2];
	assign det_en    = s_q.osc[B_PFEN];
	assign fail_ev   = det_en & ~edge_seen &
	                   (s_q.cnt == CNT_W'(FAIL_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		// pin synchroniser, stage 0 feeds stage 1 only
		s_d.sy = {s_q.sy[1:0], prim_osc_in};

		// unlock tracker and guarded write
		if (osc_wr) begin
			unique case (s_q.fsm)
				LK_LOCKED: begin
					if (pwdata[7:0] == KEY_1) begin
						s_d.fsm = LK_KEY1;
					end
				end
				LK_KEY1: begin
					// a repeated first key restarts the pair
					if (pwdata[7:0] == KEY_2) begin
						s_d.fsm = LK_OPEN;
					end else if (pwdata[7:0] == KEY_1) begin
						s_d.fsm = LK_KEY1;
					end else begin
						s_d.fsm = LK_LOCKED;
					end
				end
				LK_OPEN: begin
					s_d.osc = pwdata[7:0];
					s_d.fsm = LK_LOCKED;
					s_d.rec = 1'b0;
				end
				default: begin
					s_d.fsm = LK_LOCKED;
				end
			endcase
		end

		// status clear by writing ones, set wins below
		if (wr && paddr == OFF_STS) begin
			s_d.sts = s_d.sts & ~pwdata[ST_W-1:0];
		end
		if (wr && paddr == OFF_MSK) begin
			s_d.msk = pwdata[ST_W-1:0];
		end
		// set after the clear, so an ignored write beats a w1c in one cycle
		if (ign_ev) begin
			s_d.sts[ST_IGN] = 1'b1;
		end

		// slow clock watchdog counter, saturates once it has fired
		if (!det_en || edge_seen) begin
			s_d.cnt = '0;
		end else if (s_q.cnt != CNT_W'(FAIL_CYCLES)) begin
			s_d.cnt = s_q.cnt + CNT_W'(1);
		end

		// failure is non-maskable, recovery only onto a live watchdog osc
		if (fail_ev) begin
			s_d.sts[ST_FAIL] = 1'b1;
			if (s_q.osc[B_WDTOSC] &&
			    s_q.osc[SEL_LO +: SEL_W] != SRC_WDT) begin
				s_d.rec = 1'b1;
			end
		end

		// effective source follows the register unless recovering
		s_d.src = s_d.rec ? SRC_WDT : s_d.osc[SEL_LO +: SEL_W];
		s_d.nmi = s_d.sts[ST_FAIL];
		s_d.irq = |(s_d.sts & s_d.msk);

		// read data captured in setup, so access is zero wait
		s_d.rdy = setup;
		s_d.err = setup & ~mapped;
		s_d.rdata = '0;
		if (setup && !pwrite) begin
			unique case (paddr)
				OFF_OSC:  s_d.rdata[7:0] = s_q.osc;
				OFF_STS:  s_d.rdata[ST_W-1:0] = s_q.sts;
				OFF_MSK:  s_d.rdata[ST_W-1:0] = s_q.msk;
				OFF_STAT: begin
					s_d.rdata[RB_FSM +: 3] = s_q.fsm;
					s_d.rdata[RB_REC] = s_q.rec;
					s_d.rdata[RB_SRC +: SEL_W] = s_q.src;
				end
				default:  s_d.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	// reset leaves the tracker locked and the precision osc running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q       <= '0;
			s_q.fsm   <= LK_LOCKED;
			s_q.osc   <= OSC_RST;
			s_q.src   <= SRC_IPO;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata     = s_q.rdata;
	assign pready     = s_q.rdy;
	assign pslverr    = s_q.err;
	assign ipo_en     = s_q.osc[B_IPO];
	assign xtal_en    = s_q.osc[B_XTAL];
	assign wdt_osc_en = s_q.osc[B_WDTOSC];
	assign clk_src    = s_q.src;
	assign recovery   = s_q.rec;
	assign nmi        = s_q.nmi;
	assign irq        = s_q.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_key1;
		ce && osc_wr && pwdata[7:0] == KEY_1;
	endsequence

	sequence s_key2;
		ce && osc_wr && pwdata[7:0] == KEY_2;
	endsequence

	sequence s_other;
		ce && access && paddr != OFF_OSC;
	endsequence

	key_first_a: assert property (
		s_key1 and (s_q.fsm == LK_LOCKED) |=> s_q.fsm == LK_KEY1
	) else $error("first key not tracked");

	key_pair_a: assert property (
		(s_q.fsm == LK_KEY1) and s_key2 |=> s_q.fsm == LK_OPEN
	) else $error("key pair did not open");

	store_write_a: assert property (
		ce && osc_wr && s_q.fsm == LK_OPEN |=>
			s_q.osc == $past(pwdata[7:0]) && s_q.fsm == LK_LOCKED
	) else $error("open write not stored or not relocked");

	ignore_write_a: assert property (
		ce && osc_wr && s_q.fsm != LK_OPEN |=> $stable(s_q.osc)
	) else $error("locked write changed register");

	other_access_a: assert property (
		(s_q.fsm == LK_KEY1) and s_other |=> s_q.fsm == LK_KEY1
	) else $error("other access broke unlock");

	ipo_hold_a: assert property (
		$fell(ipo_en) |-> $past(osc_wr && s_q.fsm == LK_OPEN && ce)
	) else $error("precision osc turned off by hardware");

	fail_nmi_a: assert property (
		ce && fail_ev |=> nmi && s_q.sts[ST_FAIL] ##1 (nmi || !ce || wr)
	) else $error("failure did not raise nmi");

	recov_gate_a: assert property (
		$rose(recovery) |-> $past(wdt_osc_en && s_q.osc[SEL_LO +: SEL_W] != SRC_WDT)
			&& clk_src == SRC_WDT
	) else $error("recovery without live watchdog osc");

	fail_time_a: assert property (
		ce && det_en && edge_seen |=> s_q.cnt == '0 && !fail_ev
	) else $error("osc edge did not restart fail timer");

	reset_lock_a: assert property (
		@(posedge pclk) $rose(presetn) |-> s_q.fsm == LK_LOCKED && s_q.osc == OSC_RST
	) else $error("reset left tracker unlocked");

	ign_set_a: assert property (
		ce && ign_ev |=> s_q.sts[ST_IGN]
	) else $error("ignored write not flagged");

	bad_key_a: assert property (
		ce && ign_ev && s_q.fsm == LK_KEY1 |=> s_q.fsm == LK_LOCKED
	) else $error("bad second key did not relock");

	key_restart_a: assert property (
		(s_q.fsm == LK_KEY1) and s_key1 |=> s_q.fsm == LK_KEY1
	) else $error("repeated first key lost");

	open_hold_a: assert property (
		(s_q.fsm == LK_OPEN) and s_other |=> s_q.fsm == LK_OPEN
	) else $error("other access closed unlock");

	osc_only_a: assert property (
		!(ce && osc_wr && s_q.fsm == LK_OPEN) |=> $stable(s_q.osc)
	) else $error("control register changed without open write");

	rec_clear_a: assert property (
		ce && osc_wr && s_q.fsm == LK_OPEN && !fail_ev |=> !recovery
	) else $error("stored write left recovery set");

	rec_hold_a: assert property (
		recovery && !(ce && osc_wr && s_q.fsm == LK_OPEN) |=> recovery
	) else $error("recovery dropped by itself");

	nmi_level_a: assert property (
		nmi == s_q.sts[ST_FAIL]
	) else $error("nmi does not follow failure bit");

	fail_keep_a: assert property (
		s_q.sts[ST_FAIL] && !wr |=> s_q.sts[ST_FAIL]
	) else $error("failure bit dropped without clear");

	src_follow_a: assert property (
		clk_src == (recovery ? SRC_WDT : s_q.osc[SEL_LO +: SEL_W])
	) else $error("clock source does not follow register");

	no_recov_a: assert property (
		ce && fail_ev && !wdt_osc_en && !recovery |=> !recovery
	) else $error("recovery onto stopped watchdog osc");

	recov_src_a: assert property (
		ce && fail_ev && !recovery && s_q.osc[SEL_LO +: SEL_W] == SRC_WDT |=> !recovery
	) else $error("recovery while watchdog osc is primary");

	cnt_off_a: assert property (
		ce && !det_en |=> s_q.cnt == '0
	) else $error("fail timer runs while detection off");

	fail_once_a: assert property (
		ce && fail_ev |=> !fail_ev
	) else $error("failure event repeated");

	irq_level_a: assert property (
		irq == |(s_q.sts & s_q.msk)
	) else $error("irq does not follow masked status");

	clr_sts_a: assert property (
		ce && wr && paddr == OFF_STS && pwdata[ST_FAIL] && !fail_ev |=> !s_q.sts[ST_FAIL]
	) else $error("failure bit not cleared by write");

	msk_store_a: assert property (
		ce && wr && paddr == OFF_MSK |=> s_q.msk == $past(pwdata[ST_W-1:0])
	) else $error("mask write not stored");

	ready_pulse_a: assert property (
		ce && pready |=> !pready
	) else $error("pready longer than one cycle");

	err_ready_a: assert property (
		pslverr |-> pready
	) else $error("pslverr without pready");

	rdata_idle_a: assert property (
		!pready |-> prdata == '0
	) else $error("read data outside access cycle");

endmodule

/* File: tb/tb.sv */
// self-checking bench for the oscillator lock and fail recovery block
`timescale 1ns/1ps
module tb;
	import osl_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, prim_osc_in, osc_run, e;
	logic        pready, pslverr, ipo_en, xtal_en, wdt_osc_en, recovery, nmi, irq;
	logic [2:0]  clk_src;
	logic [7:0]  paddr, v, cur;
	logic [31:0] pwdata, prdata, r;
	int          failures, comparisons, seed, n;
	logic [7:0]  tbl [3] = '{8'hB0, 8'h90, 8'hB3};

	osl_top #(.FAIL_CYCLES(20)) uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .prim_osc_in(prim_osc_in), .ipo_en(ipo_en),
		.xtal_en(xtal_en), .wdt_osc_en(wdt_osc_en), .clk_src(clk_src),
		.recovery(recovery), .nmi(nmi), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	// clock, and primary activity toggling every cycle while running
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) prim_osc_in <= prim_osc_in ^ osc_run;

	////////////////////////////////////////////////////////////////////////////////
	// compare, count, report
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one apb transfer; idle edge after it so no signal is driven twice per step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			failures++;
			tally_and_finish;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task unl(input logic [7:0] d);
		wr(OFF_OSC, KEY_1);
		wr(OFF_OSC, KEY_2);
		wr(OFF_OSC, d);
	endtask
	// recovery only with watchdog osc on and not already the source
	function logic exp_rec(input logic [7:0] o);
		return o[B_WDTOSC] && o[2:0] != SRC_WDT;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 32'hba9b0f1e;
		{psel, penable, pwrite, osc_run, prim_osc_in} = '0;
		paddr = '0;
		pwdata = '0;
		failures = 0;
		comparisons = 0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({ipo_en, xtal_en, wdt_osc_en, clk_src, recovery, nmi, irq}, 9'h140);
		rd(OFF_OSC);
		chk(r, {24'h0, OSC_RST});
		rd(OFF_STAT);
		chk(r[2:0], LK_LOCKED);
		cur = OSC_RST;
		// stray write, then keys split by other accesses, then a stored value
		for (int i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			if (v == KEY_1) v = 8'h00;
			wr(OFF_OSC, v);
			rd(OFF_OSC);
			chk(r[7:0], cur);
			v = (i == 0) ? 8'h81 : 8'($random(seed));
			v[B_PFEN] = 1'b0;
			wr(OFF_OSC, KEY_1);
			rd(OFF_STAT);
			chk(r[2:0], LK_KEY1);
			wr(OFF_STS, 8'h00);
			wr(OFF_OSC, KEY_2);
			wr(OFF_OSC, v);
			wr(OFF_OSC, 8'h55);
			rd(OFF_OSC);
			chk(r[7:0], v);
			chk({ipo_en, xtal_en, wdt_osc_en, clk_src}, {v[7:5], v[2:0]});
			cur = v;
		end
		// keys in the wrong order open nothing
		wr(OFF_OSC, KEY_2);
		wr(OFF_OSC, KEY_1);
		wr(OFF_OSC, 8'h00);
		rd(OFF_STAT);
		chk(r[2:0], LK_LOCKED);
		rd(OFF_OSC);
		chk(r[7:0], cur);
		// ignored writes leave the flag up until a one clears it
		rd(OFF_STS);
		chk(r[1:0], 2'b10);
		wr(OFF_STS, 8'h02);
		rd(OFF_STS);
		chk(r[1:0], 2'b00);
		// reset between the keys drops the half-entered sequence
		wr(OFF_OSC, KEY_1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		wr(OFF_OSC, KEY_2);
		wr(OFF_OSC, 8'h01);
		rd(OFF_OSC);
		chk(r[7:0], OSC_RST);
		// unmapped address
		wr(8'h10, 8'hFF);
		rd(8'h10);
		chk(e, 1'b1);
		chk(r, 32'h0);
		// stop the primary oscillator with detection on, three recovery cases
		wr(OFF_MSK, 8'h01);
		for (int i = 0; i < 3; i++) begin
			osc_run <= 1'b1;
			unl(tbl[i]);
			wr(OFF_STS, 8'h03);
			repeat (30) @(posedge pclk);
			chk(nmi, 1'b0);
			osc_run <= 1'b0;
			n = 0;
			while (nmi !== 1'b1 && n < 60) begin
				@(posedge pclk);
				n++;
			end
			if (n >= 60) begin
				failures++;
				tally_and_finish;
			end
			// nominal 20 cycles, fifty percent either way
			chk(n >= 10 && n <= 30, 1'b1);
			repeat (2) @(posedge pclk);
			chk({nmi, irq, recovery, clk_src},
				{2'b11, exp_rec(tbl[i]), exp_rec(tbl[i]) ? SRC_WDT : tbl[i][2:0]});
			unl(8'hA0);
			wr(OFF_STS, 8'h03);
			repeat (2) @(posedge pclk);
			chk({nmi, irq, recovery}, 3'b000);
		end
		tally_and_finish;
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		tally_and_finish;
	end
endmodule
